// ---- bench/ipios_io_model.sv ----
// switches, sensors and actuators hanging on the io lines
`timescale 1ns/1ps
module ipios_io_model (
    input  wire logic                              pclk,          // clock
    input  wire logic [ipios_pkg::N_IN_LINES-1:0]  contact,       // switch closed when 1
    input  wire logic [ipios_pkg::N_OUT_LINES-1:0] sys_drive,     // system output states
    input  wire logic [ipios_pkg::N_OUT_LINES-1:0] out_line,      // driven output pins
    output logic      [ipios_pkg::N_IN_LINES-1:0]  in_line,       // input pin levels
    output logic      [ipios_pkg::N_OUT_LINES-1:0] sys_out_state, // to the block
    output logic      [ipios_pkg::N_OUT_LINES-1:0] load_on        // actuators energised
);
    // a closed contact pulls its line high; six lines in, four out
    assign in_line = contact;
    // system outputs come from same clock logic, so register them here
    always_ff @(posedge pclk)
    begin
        sys_out_state <= sys_drive;
        load_on       <= out_line;
    end
endmodule : ipios_io_model

// ---- bench/ipios_top_asserts.sv ----
// port level assertion checker for the input polarity block
`timescale 1ns/1ps
module ipios_top_asserts (
    input wire logic                              pclk,     // clock
    input wire logic                              presetn,  // reset, low
    input wire logic                              psel,     // apb select
    input wire logic                              penable,  // apb enable
    input wire logic [ipios_pkg::DATA_W-1:0]      prdata,   // read data
    input wire logic                              pslverr,  // apb error
    input wire logic [ipios_pkg::N_IN_LINES-1:0]  in_line,  // input pins
    input wire logic [ipios_pkg::N_OUT_LINES-1:0] out_line, // output pins
    input wire logic [ipios_pkg::N_IN_LINES-1:0]  sys_in_active, // system inputs
    input wire logic [ipios_pkg::N_GP_INPUTS-1:0] single_general_input_state, // general
    input wire logic [ipios_pkg::SEQ_W-1:0]       selected_sequence_number, // sequence
    input wire logic                              seq_select_valid // mode 0
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // sequence number only means something in mode 0
    a_seq_off_zero: assert property (!seq_select_valid
        |-> selected_sequence_number == 6'h00)
        else $error("sequence number nonzero outside mode 0");
    // registered one stage apart, so compare only when general state held
    a_seq_from_gen: assert property (seq_select_valid && $past(seq_select_valid)
        && $stable(single_general_input_state)
        |-> selected_sequence_number == single_general_input_state[6:1])
        else $error("sequence number differs from general inputs");
    a_gen0_inactive: assert property (single_general_input_state[0] == 1'b0)
        else $error("general input 0 active");
    a_assigned_gen_zero: assert property ($stable(sys_in_active)
        |-> (sys_in_active & single_general_input_state[6:1]) == 6'h00)
        else $error("assigned line also shown as general input");
    a_slverr_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    a_prdata_stands: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data changed outside setup");
    a_reset_inactive: assert property (!$past(presetn)
        |-> single_general_input_state == 7'h00
        && sys_in_active == 6'h00 && out_line == 4'h0)
        else $error("outputs active straight after reset");
    // quiet pins and no register traffic must leave the states alone
    a_inputs_settle: assert property ((!psel && $stable(in_line)) [*7]
        |-> $stable(single_general_input_state) && $stable(sys_in_active))
        else $error("input state moved with pins quiet");

    c_refused: cover property (pslverr);
    c_seq_nonzero: cover property (seq_select_valid && selected_sequence_number != 6'h00);
    c_sys_active: cover property (sys_in_active != 6'h00);
endmodule : ipios_top_asserts

bind ipios_top ipios_top_asserts i_ipios_top_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
    .pslverr(pslverr), .in_line(in_line), .out_line(out_line),
    .sys_in_active(sys_in_active), .single_general_input_state(single_general_input_state),
    .selected_sequence_number(selected_sequence_number), .seq_select_valid(seq_select_valid));

// ---- bench/ipios_top_test.sv ----
// self-checking bench for the input polarity block
`timescale 1ns/1ps
module ipios_top_test;
    logic                              pclk, presetn, nv_erase_n;     // clock and resets
    logic                              psel, penable, pwrite;         // apb control
    logic [ipios_pkg::ADDR_W-1:0]      paddr;                         // apb address
    logic [ipios_pkg::DATA_W-1:0]      pwdata, prdata, rd;            // apb data
    logic [3:0]                        pstrb;                         // apb strobes
    logic                              pready, pslverr, err, seq_valid; // status bits
    logic [ipios_pkg::N_IN_LINES-1:0]  in_line, sys_in_active, contact; // input side
    logic [ipios_pkg::N_OUT_LINES-1:0] out_line, sys_out_state, sys_drive, load_on; // outputs
    logic [ipios_pkg::N_GP_INPUTS-1:0] gen_state;                     // general inputs
    logic [ipios_pkg::SEQ_W-1:0]       seq_num;                       // sequence number
    int                                n_errors, tests_run;           // counters

    ipios_top i_ipios_top (.pclk(pclk), .presetn(presetn), .nv_erase_n(nv_erase_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_line(in_line), .out_line(out_line), .sys_out_state(sys_out_state),
        .sys_in_active(sys_in_active), .single_general_input_state(gen_state),
        .selected_sequence_number(seq_num), .seq_select_valid(seq_valid));
    ipios_io_model i_ipios_io_model (.pclk(pclk), .contact(contact), .sys_drive(sys_drive),
        .out_line(out_line), .in_line(in_line), .sys_out_state(sys_out_state),
        .load_on(load_on));

    // 250 MHz clock
    always #2 pclk = ~pclk;

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer; waits an edge first so no signal is driven twice at once
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask : rchk

    // pin to status path takes four edges, give it six
    task automatic settle();
        repeat (6) @(posedge pclk);
    endtask : settle

    task automatic rst_pulse(input logic erase);
        @(posedge pclk);
        presetn    <= 1'b0;
        nv_erase_n <= ~erase;
        repeat (2) @(posedge pclk);
        presetn    <= 1'b1;
        nv_erase_n <= 1'b1;
        settle();
    endtask : rst_pulse

    task automatic t_defaults();
        rchk(ipios_pkg::OFS_POL_ACTIVE, 32'h0000_0000);
        rchk(ipios_pkg::OFS_POL_SAVED, 32'h0000_0000);
        rchk(12'h030, 32'h0000_0000);
        check(32'(err), 32'h1);
        contact <= 6'h05;
        settle();
        check(32'(gen_state), 32'h0000_000a);
        check(32'(seq_num), 32'h0000_0005);
        rchk(ipios_pkg::OFS_IO_STATUS, 32'h0105_0005);
    endtask : t_defaults

    // new polarity waits for save and reset; lines 1 and 3 normally closed
    task automatic t_save();
        apb(1'b1, ipios_pkg::OFS_POL_PEND, 32'h0000_000a);
        rchk(ipios_pkg::OFS_POL_ACTIVE, 32'h0000_0000);
        apb(1'b1, ipios_pkg::OFS_CMD, 32'h0000_0001);
        rchk(ipios_pkg::OFS_POL_SAVED, 32'h0000_010a);
        rchk(ipios_pkg::OFS_POL_ACTIVE, 32'h0000_0000);
        rst_pulse(1'b0);
        rchk(ipios_pkg::OFS_POL_ACTIVE, 32'h0000_000a);
        check(32'(gen_state), 32'h0000_0000);
        contact <= 6'h00;
        settle();
        check(32'(gen_state), 32'h0000_000a);
        rchk(ipios_pkg::OFS_GEN_INPUT, 32'h0000_000a);
    endtask : t_save

    // polarity writes refused outside mode 0; unsaved change lost at reset
    task automatic t_mode();
        apb(1'b1, ipios_pkg::OFS_POL_PEND, 32'h0000_0014);
        apb(1'b1, ipios_pkg::OFS_MODE, 32'h0000_0001);
        settle();
        check(32'(seq_valid), 32'h0);
        check(32'(seq_num), 32'h0);
        apb(1'b1, ipios_pkg::OFS_POL_PEND, 32'h0000_007f);
        check(32'(err), 32'h1);
        rchk(ipios_pkg::OFS_POL_PEND, 32'h0000_0014);
        rst_pulse(1'b0);
        rchk(ipios_pkg::OFS_POL_ACTIVE, 32'h0000_000a);
        rst_pulse(1'b1);
        rchk(ipios_pkg::OFS_POL_ACTIVE, 32'h0000_0000);
        rchk(ipios_pkg::OFS_POL_SAVED, 32'h0000_0000);
    endtask : t_mode

    // line 2 to a system input active low, output 4 to a system output
    task automatic t_assign();
        apb(1'b1, ipios_pkg::OFS_IN_ASSIGN, 32'h0000_0202);
        settle();
        check(32'(sys_in_active), 32'h0000_0002);
        check(32'(gen_state), 32'h0000_0000);
        contact <= 6'h03;
        apb(1'b1, ipios_pkg::OFS_OUT_ASSIGN, 32'h0000_0008);
        apb(1'b1, ipios_pkg::OFS_GP_OUT, 32'h0000_0003);
        sys_drive <= 4'hc;
        settle();
        check(32'(sys_in_active), 32'h0000_0000);
        check(32'(gen_state), 32'h0000_0002);
        check(32'(out_line), 32'h0000_000b);
        check(32'(load_on), 32'h0000_000b);
        rchk(ipios_pkg::OFS_IO_STATUS, 32'h0101_0b01);
    endtask : t_assign

    initial
    begin
        {pclk, presetn, nv_erase_n, psel, penable, pwrite} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        contact = 6'h00;
        sys_drive = 4'h0;
        n_errors = 0;
        tests_run = 0;
        repeat (12) @(posedge pclk);
        presetn    <= 1'b1;
        nv_erase_n <= 1'b1;
        settle();
        t_defaults();
        t_save();
        t_mode();
        t_assign();
        finish_test();
    end

    // whole run is under two thousand cycles
    initial
    begin
        #40000;
        n_errors++;
        finish_test();
    end
endmodule : ipios_top_test

// ---- design/ipios_line_cond.sv ----
// one input line: two flop synchroniser then active level inversion
`timescale 1ns/1ps
module ipios_line_cond (
    input  wire logic pclk,      // system clock
    input  wire logic presetn,   // async reset, active low
    input  wire logic raw_line,  // asynchronous pin level
    input  wire logic invert,    // 1: normally closed
    output logic      line_sync, // synchronised raw level
    output logic      active     // active state
);
    logic meta_r;
    logic sync_r;
    logic active_r;
    logic active_nxt;

    // active level applied after synchronising
    always_comb
    begin
        active_nxt = sync_r ^ invert;
    end

    // meta_r is read only by sync_r
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_r   <= 1'b0;
            sync_r   <= 1'b0;
            active_r <= 1'b0;
        end
        else
        begin
            meta_r   <= raw_line;
            sync_r   <= meta_r;
            active_r <= active_nxt;
        end
    end

    assign line_sync = sync_r;
    assign active    = active_r;
endmodule : ipios_line_cond

// ---- design/ipios_nv_store.sv ----
// nonvolatile polarity store, kept across device reset, cleared only by erase
`timescale 1ns/1ps
module ipios_nv_store (
    input  wire logic                             pclk,      // system clock
    input  wire logic                             nv_erase_n, // erase/first power, low
    input  wire logic                             save,      // one cycle save pulse
    input  wire logic [ipios_pkg::N_GP_INPUTS-1:0] wr_data,  // value to save
    output logic      [ipios_pkg::N_GP_INPUTS-1:0] rd_data,  // last saved value
    output logic                                  saved_any  // a save has happened
);
    logic [ipios_pkg::N_GP_INPUTS-1:0] data_r;
    logic [ipios_pkg::N_GP_INPUTS-1:0] data_nxt;
    logic                              valid_r;
    logic                              valid_nxt;

    // store takes the value only on a save pulse
    always_comb
    begin
        data_nxt  = data_r;
        valid_nxt = valid_r;
        if (save)
        begin
            data_nxt  = wr_data;
            valid_nxt = 1'b1;
        end
    end

    // not cleared by presetn, so a device reset keeps the saved value
    always_ff @(posedge pclk or negedge nv_erase_n)
    begin
        if (!nv_erase_n)
        begin
            data_r  <= ipios_pkg::POL_DEFAULT;
            valid_r <= 1'b0;
        end
        else
        begin
            data_r  <= data_nxt;
            valid_r <= valid_nxt;
        end
    end

    // never saved reads as the default
    assign rd_data   = valid_r ? data_r : ipios_pkg::POL_DEFAULT;
    assign saved_any = valid_r;
endmodule : ipios_nv_store

// ---- design/ipios_pkg.sv ----
// shared constants, register map and carrier types for the input polarity block
package ipios_pkg;
    // line counts and field widths
    localparam int unsigned N_IN_LINES  = 6;
    localparam int unsigned N_OUT_LINES = 4;
    localparam int unsigned N_GP_INPUTS = 7;
    localparam int unsigned ADDR_W      = 12;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned MODE_W      = 8;
    localparam int unsigned SEQ_W       = 6;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_MODE       = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_POL_PEND   = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_POL_ACTIVE = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_POL_SAVED  = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_CMD        = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_IN_ASSIGN  = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_OUT_ASSIGN = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_GP_OUT     = 12'h01c;
    localparam logic [ADDR_W-1:0] OFS_IO_STATUS  = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_GEN_INPUT  = 12'h024;

    // field positions
    localparam int unsigned CMD_SAVE_BIT     = 0;
    localparam int unsigned SAVED_VALID_BIT  = 8;
    localparam int unsigned IN_LEVEL_LSB     = 8;
    localparam int unsigned ST_OUT_LSB       = 8;
    localparam int unsigned ST_SEQ_LSB       = 16;
    localparam int unsigned ST_SEQ_VALID_BIT = 24;

    // reset and default values
    localparam logic [MODE_W-1:0]      MODE_RST     = 8'h00;
    localparam logic [MODE_W-1:0]      MODE_SEQSEL  = 8'h00;
    localparam logic [N_GP_INPUTS-1:0] POL_DEFAULT  = 7'h00;
    localparam logic [N_IN_LINES-1:0]  IN_MASK_RST  = 6'h00;
    localparam logic [N_OUT_LINES-1:0] OUT_MASK_RST = 4'h0;
    localparam logic [DATA_W-1:0]      DATA_ZERO    = 32'h0000_0000;

    // polarity encoding
    localparam logic POL_NORM_OPEN   = 1'b0;
    localparam logic POL_NORM_CLOSED = 1'b1;

    // live io status carried to the status register and ports
    typedef struct packed {
        logic [N_IN_LINES-1:0]  in_active;
        logic [N_OUT_LINES-1:0] out_active;
        logic [SEQ_W-1:0]       seq_num;
        logic                   seq_valid;
    } ipios_status_t;

    // system signal assignment of the lines
    typedef struct packed {
        logic [N_IN_LINES-1:0]  in_sys;
        logic [N_IN_LINES-1:0]  in_sys_level;
        logic [N_OUT_LINES-1:0] out_sys;
    } ipios_assign_t;
endpackage : ipios_pkg

// ---- design/ipios_top.sv ----
// input polarity and io status block with apb register access
//
// What this block does
// RULE1: hold polarity per general input 0 to 6
// RULE2: polarity writes accepted only when mode is 0
// RULE3: new polarity applies only after save and reset
// RULE4: at reset restore polarity from saved value
// RULE5: never saved means default normally open
// RULE6: system assigned lines use the signal level
// RULE7: status shows every input and output active
// RULE8: assigned lines show their system signal state
// RULE9: mode 0 general inputs give sequence number
// RULE10: six input lines and four output lines
// RULE11: normally closed inverts line, open passes it
// RULE12: assigned general input reads as inactive
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
module ipios_top (
    input  wire logic                               pclk,         // 250 MHz clock
    input  wire logic                               presetn,      // async reset, low
    input  wire logic                               nv_erase_n,   // nv store erase, low
    input  wire logic                               psel,         // apb select
    input  wire logic                               penable,      // apb enable
    input  wire logic                               pwrite,       // apb direction
    input  wire logic [ipios_pkg::ADDR_W-1:0]       paddr,        // apb byte address
    input  wire logic [ipios_pkg::DATA_W-1:0]       pwdata,       // apb write data
    input  wire logic [3:0]                         pstrb,        // apb byte strobes
    output logic      [ipios_pkg::DATA_W-1:0]       prdata,       // apb read data
    output logic                                    pready,       // apb ready
    output logic                                    pslverr,      // apb error
    input  wire logic [ipios_pkg::N_IN_LINES-1:0]   in_line,      // input pins 1..6
    output logic      [ipios_pkg::N_OUT_LINES-1:0]  out_line,     // output pins 1..4
    input  wire logic [ipios_pkg::N_OUT_LINES-1:0]  sys_out_state, // system output states
    output logic      [ipios_pkg::N_IN_LINES-1:0]   sys_in_active, // system input states
    output logic      [ipios_pkg::N_GP_INPUTS-1:0]  single_general_input_state, // per input
    output logic      [ipios_pkg::SEQ_W-1:0]        selected_sequence_number,   // sequence
    output logic                                    seq_select_valid            // mode is 0
);
    localparam int unsigned NI = ipios_pkg::N_IN_LINES;
    localparam int unsigned NO = ipios_pkg::N_OUT_LINES;
    localparam int unsigned NG = ipios_pkg::N_GP_INPUTS;

    // register state
    logic [ipios_pkg::MODE_W-1:0] mode_r;
    logic [ipios_pkg::MODE_W-1:0] mode_nxt;
    logic [NG-1:0]                pol_pend_r;
    logic [NG-1:0]                pol_pend_nxt;
    logic [NG-1:0]                pol_act_r;
    logic [NG-1:0]                pol_act_nxt;
    logic                         loaded_r;
    logic                         loaded_nxt;
    ipios_pkg::ipios_assign_t     asg_r;
    ipios_pkg::ipios_assign_t     asg_nxt;
    logic [NO-1:0]                gp_out_r;
    logic [NO-1:0]                gp_out_nxt;
    logic [NO-1:0]                out_line_r;
    logic [NO-1:0]                out_line_nxt;
    logic [ipios_pkg::DATA_W-1:0] prdata_r;
    logic [ipios_pkg::DATA_W-1:0] prdata_nxt;
    ipios_pkg::ipios_status_t     st_r;
    ipios_pkg::ipios_status_t     st_nxt;
    logic [NG-1:0]                gen_r;
    logic [NG-1:0]                gen_nxt;

    // bus decode
    logic                         setup_ph;
    logic                         wr_acc;
    logic                         addr_ok;
    logic                         pol_locked;
    logic                         save_pulse;
    logic                         full_word;

    // nv store
    logic [NG-1:0]                nv_data;
    logic                         nv_valid;

    // conditioned lines
    logic [NI-1:0]                line_inv;
    logic [NI-1:0]                line_sync;
    logic [NI-1:0]                line_act;

    // apb phases: zero wait states, data latched in setup
    assign setup_ph  = psel && !penable;
    assign wr_acc    = psel && penable && pwrite;
    assign full_word = (pstrb != 4'h0);
    assign pready    = 1'b1;

    // address decode; unmapped answers with an error
    always_comb
    begin
        unique case (paddr)
            ipios_pkg::OFS_MODE,
            ipios_pkg::OFS_POL_PEND,
            ipios_pkg::OFS_POL_ACTIVE,
            ipios_pkg::OFS_POL_SAVED,
            ipios_pkg::OFS_CMD,
            ipios_pkg::OFS_IN_ASSIGN,
            ipios_pkg::OFS_OUT_ASSIGN,
            ipios_pkg::OFS_GP_OUT,
            ipios_pkg::OFS_IO_STATUS,
            ipios_pkg::OFS_GEN_INPUT: addr_ok = 1'b1;
            default:                  addr_ok = 1'b0;
        endcase
    end

    // polarity write outside mode 0 is refused with an error
    assign pol_locked = (mode_r != ipios_pkg::MODE_SEQSEL); // RULE2
    assign pslverr    = psel && penable &&
                        (!addr_ok || (pwrite && pol_locked &&
                                      paddr == ipios_pkg::OFS_POL_PEND));

    assign save_pulse = wr_acc && full_word && paddr == ipios_pkg::OFS_CMD &&
                        pwdata[ipios_pkg::CMD_SAVE_BIT];

    // saved polarity survives presetn
    ipios_nv_store u_nv (
        .pclk       (pclk),
        .nv_erase_n (nv_erase_n),
        .save       (save_pulse),
        .wr_data    (pol_pend_r),
        .rd_data    (nv_data),     // RULE5
        .saved_any  (nv_valid)
    );

    // level per physical line: system level if assigned, else general polarity
    always_comb
    begin
        for (int i = 0; i < NI; i++)
        begin
            line_inv[i] = asg_r.in_sys[i] ? asg_r.in_sys_level[i] // RULE6
                                          : pol_act_r[i + 1];
        end
    end

    // input line i+1 conditioned; general input 0 has no pin
    for (genvar g = 0; g < NI; g++)
    begin : g_line
        ipios_line_cond u_cond (
            .pclk      (pclk),
            .presetn   (presetn),
            .raw_line  (in_line[g]),  // RULE10
            .invert    (line_inv[g]), // RULE11
            .line_sync (line_sync[g]),
            .active    (line_act[g])
        );
    end

    // general state per input; assigned ones read inactive
    always_comb
    begin
        gen_nxt = '0;
        for (int i = 0; i < NI; i++)
        begin
            gen_nxt[i + 1] = line_act[i] && !asg_r.in_sys[i]; // RULE12
        end
    end

    // io status and sequence selection
    always_comb
    begin
        st_nxt            = st_r;
        st_nxt.in_active  = line_act;                          // RULE7 RULE8
        for (int j = 0; j < NO; j++)
        begin
            st_nxt.out_active[j] = asg_r.out_sys[j] ? sys_out_state[j] // RULE8
                                                    : gp_out_r[j];      // RULE7
        end
        st_nxt.seq_valid = !pol_locked;                        // RULE9
        st_nxt.seq_num   = pol_locked ? '0 : gen_r[NG-1:1];    // RULE9
        out_line_nxt     = (asg_r.out_sys & sys_out_state) |
                           (~asg_r.out_sys & gp_out_r);
    end

    // register writes; polarity takes effect only through the store and a reset
    always_comb
    begin
        mode_nxt     = mode_r;
        pol_pend_nxt = pol_pend_r;
        asg_nxt      = asg_r;
        gp_out_nxt   = gp_out_r;
        pol_act_nxt  = pol_act_r; // RULE3
        loaded_nxt   = 1'b1;
        // first cycle after reset release copies the saved value in
        if (!loaded_r)
        begin
            pol_act_nxt = nv_data; // RULE4
        end
        if (wr_acc && full_word)
        begin
            unique case (paddr)
                ipios_pkg::OFS_MODE:
                    mode_nxt = pwdata[ipios_pkg::MODE_W-1:0];
                ipios_pkg::OFS_POL_PEND:
                    if (!pol_locked)
                    begin
                        pol_pend_nxt = pwdata[NG-1:0]; // RULE1 RULE2
                    end
                ipios_pkg::OFS_IN_ASSIGN:
                begin
                    asg_nxt.in_sys       = pwdata[NI-1:0];
                    asg_nxt.in_sys_level = pwdata[ipios_pkg::IN_LEVEL_LSB +: NI];
                end
                ipios_pkg::OFS_OUT_ASSIGN:
                    asg_nxt.out_sys = pwdata[NO-1:0];
                ipios_pkg::OFS_GP_OUT:
                    gp_out_nxt = pwdata[NO-1:0];
                default:
                begin
                end
            endcase
        end
    end

    // read data captured in the setup cycle
    always_comb
    begin
        prdata_nxt = prdata_r;
        if (setup_ph)
        begin
            prdata_nxt = ipios_pkg::DATA_ZERO;
            unique case (paddr)
                ipios_pkg::OFS_MODE:
                    prdata_nxt[ipios_pkg::MODE_W-1:0] = mode_r;
                ipios_pkg::OFS_POL_PEND:
                    prdata_nxt[NG-1:0] = pol_pend_r;
                ipios_pkg::OFS_POL_ACTIVE:
                    prdata_nxt[NG-1:0] = pol_act_r;
                ipios_pkg::OFS_POL_SAVED:
                begin
                    prdata_nxt[NG-1:0]                       = nv_data;
                    prdata_nxt[ipios_pkg::SAVED_VALID_BIT]   = nv_valid;
                end
                ipios_pkg::OFS_IN_ASSIGN:
                begin
                    prdata_nxt[NI-1:0]                        = asg_r.in_sys;
                    prdata_nxt[ipios_pkg::IN_LEVEL_LSB +: NI] = asg_r.in_sys_level;
                end
                ipios_pkg::OFS_OUT_ASSIGN:
                    prdata_nxt[NO-1:0] = asg_r.out_sys;
                ipios_pkg::OFS_GP_OUT:
                    prdata_nxt[NO-1:0] = gp_out_r;
                ipios_pkg::OFS_IO_STATUS:
                begin
                    prdata_nxt[NI-1:0]                          = st_r.in_active;
                    prdata_nxt[ipios_pkg::ST_OUT_LSB +: NO]     = st_r.out_active;
                    prdata_nxt[ipios_pkg::ST_SEQ_LSB +: ipios_pkg::SEQ_W] = st_r.seq_num;
                    prdata_nxt[ipios_pkg::ST_SEQ_VALID_BIT]     = st_r.seq_valid;
                end
                ipios_pkg::OFS_GEN_INPUT:
                    prdata_nxt[NG-1:0] = gen_r;
                default:
                begin
                end
            endcase
        end
    end

    // all state registered here; reset loads constants only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_r     <= ipios_pkg::MODE_RST;
            pol_pend_r <= ipios_pkg::POL_DEFAULT;
            pol_act_r  <= ipios_pkg::POL_DEFAULT;
            loaded_r   <= 1'b0;
            asg_r      <= '{in_sys:       ipios_pkg::IN_MASK_RST,
                            in_sys_level: ipios_pkg::IN_MASK_RST,
                            out_sys:      ipios_pkg::OUT_MASK_RST};
            gp_out_r   <= ipios_pkg::OUT_MASK_RST;
            out_line_r <= ipios_pkg::OUT_MASK_RST;
            prdata_r   <= ipios_pkg::DATA_ZERO;
            st_r       <= '0;
            gen_r      <= '0;
        end
        else
        begin
            mode_r     <= mode_nxt;
            pol_pend_r <= pol_pend_nxt;
            pol_act_r  <= pol_act_nxt;
            loaded_r   <= loaded_nxt;
            asg_r      <= asg_nxt;
            gp_out_r   <= gp_out_nxt;
            out_line_r <= out_line_nxt;
            prdata_r   <= prdata_nxt;
            st_r       <= st_nxt;
            gen_r      <= gen_nxt;
        end
    end

    // outputs from flops; sys_in_active is st_r.in_active masked by asg_r.in_sys
    assign prdata                     = prdata_r;
    assign out_line                   = out_line_r;
    assign sys_in_active              = st_r.in_active & asg_r.in_sys;
    assign single_general_input_state = gen_r;
    assign selected_sequence_number   = st_r.seq_num;
    assign seq_select_valid           = st_r.seq_valid;
endmodule : ipios_top
